// ===== core/sps_pkg.sv
package sps_pkg;

  // ==========================================================================
  // Register map and field layout.
  // ==========================================================================
  localparam int NREQ = 3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_XCNT = 8'h10;
  localparam int CTRL_POLL_EN = 0;
  localparam int CTRL_LOAD = 1;
  localparam logic CTRL_POLL_EN_RST = 1'b1;
  localparam int ST_POWER = 0;
  localparam int ST_REC = 1;
  localparam int ST_HALT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_PEND = 4;
  localparam int ST_STATE = 8;
  localparam int EV_LOAD_OK = 0;
  localparam int EV_HALT = 1;
  localparam int EV_XDONE = 2;
  localparam int EV_BADPATH = 3;
  localparam int EV_INTERR = 4;
  localparam int EV_W = 5;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int XCNT_W = 16;

  // ==========================================================================
  // Control states, requesters and transfer destinations.
  // ==========================================================================
  typedef enum logic [2:0] {S_OFF, S_LOAD, S_RES, S_POLL, S_SVC, S_HALT} sps_state_e;
  typedef enum logic [1:0] {SRC_TRACE, SRC_DISK, SRC_CSI} sps_src_e;
  typedef enum logic [1:0] {DST_DISK, DST_PRINT, DST_CSI, DST_MODEM} sps_dst_e;

  // Only the listed data paths may be started; anything else is refused.
  function automatic logic sps_path_ok(input logic [1:0] src, input logic [1:0] dst);
    logic ok;
    ok = 1'b0;
    case (src)
      SRC_TRACE: ok = (dst == DST_DISK);
      SRC_DISK: ok = (dst != DST_DISK);
      SRC_CSI: ok = (dst == DST_MODEM) || (dst == DST_DISK);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

// ===== core/sps_poll.sv
`timescale 1ns/1ps
module sps_poll #(
  parameter int N = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [N-1:0] req,
  input wire logic [2*N-1:0] req_dst,
  sps_poll_if.arb pif
);
  import sps_pkg::*;

  logic [N-1:0] pend_r;
  logic [1:0] dst_r [N];
  logic [1:0] ptr_r;
  logic [1:0] ptr_inc;

  // ==========================================================================
  // Pending requests.
  // ==========================================================================
  // A request stays latched until serviced; a new one beats the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= '0;
      for (int i = 0; i < N; i++) dst_r[i] <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (req[i]) begin
          pend_r[i] <= 1'b1;
          dst_r[i] <= req_dst[2*i +: 2];
        end else if (pif.take && ptr_r == 2'(i)) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Rotating scan pointer.
  // ==========================================================================
  assign ptr_inc = (ptr_r == 2'(N - 1)) ? 2'h0 : ptr_r + 2'h1;

  // The pointer parks on a pending requester so the grant stays steady.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= 2'h0;
    end else if (ce) begin
      if (pif.take || (pif.scan && !pend_r[ptr_r])) begin
        ptr_r <= ptr_inc;
      end
    end
  end

  assign pif.grant = pif.scan && pend_r[ptr_r];
  assign pif.gidx = ptr_r;
  assign pif.gdst = dst_r[ptr_r];
  assign pif.pend = pend_r;

  AST_ROTATE: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && pif.scan && !pend_r[ptr_r] |=> ptr_r == $past(ptr_inc))
    else $error("Scan pointer did not move on to the next requester.");

  AST_HOLD_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !pif.take |=> (pend_r & $past(pend_r)) == $past(pend_r))
    else $error("A pending request vanished without being serviced.");

endmodule

// ===== core/sps_poll_if.sv
`timescale 1ns/1ps
// Poll loop handshake between the supervisor and the request scanner.
interface sps_poll_if #(parameter int N = 3);
  logic [N-1:0] pend;
  logic scan;
  logic grant;
  logic [1:0] gidx;
  logic [1:0] gdst;
  logic take;
  modport ctl (output scan, output take, input grant, input gidx, input gdst, input pend);
  modport arb (input scan, input take, output grant, output gidx, output gdst, output pend);
endinterface

// ===== core/sps_supervisor.sv
`timescale 1ns/1ps
// Summary of operation
// - With the selector in remote, power follows the host's power state.
// - With the selector in local, only the panel power buttons switch power.
// - Each power-up starts an initial_microcode_load of the diagnostics.
// - The panel load button starts the same diagnostic load as a power-up.
// - Diagnostics passing leads automatically into recording mode.
// - Recording never stalls the host or takes any of its cycles.
// - An internal error with the error switch at stop halts all operation.
// - An internal error with the switch not at stop starts a new load.
// - Only one transfer runs at any time.
// - Resident routines are loaded only after a successful diagnostic load.
// - When idle, the unit polls each component in rotating order.
// - Polling stops while a request is serviced and resumes right after.
// - Only the listed source to destination data paths are allowed.
module sps_supervisor #(
  parameter int NREQ = sps_pkg::NREQ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [sps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwr_sel_remote,
  input wire logic host_power_on,
  input wire logic panel_pwr_on_btn,
  input wire logic panel_pwr_off_btn,
  input wire logic panel_load_btn,
  input wire logic err_stop_sel,
  input wire logic internal_error,
  input wire logic diag_done,
  input wire logic diag_pass,
  input wire logic resident_done,
  input wire logic [NREQ-1:0] req,
  input wire logic [2*NREQ-1:0] req_dst,
  input wire logic xfer_done,
  output logic power_en_r,
  output logic load_start_r,
  output logic resident_load_r,
  output logic recording_r,
  output logic halted_r,
  output logic host_stall_r,
  output logic xfer_go_r,
  output logic [1:0] xfer_src_r,
  output logic [1:0] xfer_dst_r,
  output logic irq_r
);
  import sps_pkg::*;

  sps_poll_if #(.N(NREQ)) pif ();

  sps_state_e st_r;
  sps_state_e st_nxt;
  logic power_nxt;
  logic load_req;
  logic err_act;
  logic path_ok;
  logic [EV_W-1:0] ev;
  logic poll_en_r;
  logic sw_load_r;
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_mask_r;
  logic [XCNT_W-1:0] xcnt_r;
  logic wr_fire;
  logic [EV_W-1:0] w1c;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  sps_poll #(.N(NREQ)) u_poll (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .req(req),
    .req_dst(req_dst),
    .pif(pif.arb)
  );

  // ==========================================================================
  // Power control.
  // ==========================================================================
  // Remote follows the host; local answers to the panel buttons only.
  always_comb begin
    if (pwr_sel_remote) begin
      power_nxt = host_power_on;
    end else if (power_en_r) begin
      power_nxt = !panel_pwr_off_btn;
    end else begin
      power_nxt = panel_pwr_on_btn;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_en_r <= 1'b0;
    end else if (ce) begin
      power_en_r <= power_nxt;
    end
  end

  // ==========================================================================
  // Supervisory state machine.
  // ==========================================================================
  assign load_req = panel_load_btn || sw_load_r;
  assign err_act = internal_error && st_r != S_OFF && st_r != S_HALT;
  assign path_ok = sps_path_ok(pif.gidx, pif.gdst);
  // Polling is suspended while a request is serviced or the poll enable bit in the control register is clear.
  assign pif.scan = ce && st_r == S_POLL && poll_en_r;
  assign pif.take = pif.scan && pif.grant && power_nxt && !load_req && !err_act;

  always_comb begin
    st_nxt = st_r;
    if (!power_nxt) begin
      st_nxt = S_OFF;
    end else if (st_r == S_OFF || load_req) begin
      st_nxt = S_LOAD;
    end else if (err_act) begin
      st_nxt = err_stop_sel ? S_HALT : S_LOAD;
    end else begin
      case (st_r)
        S_LOAD: begin
          if (diag_done) begin
            st_nxt = diag_pass ? S_RES : S_HALT;
          end
        end
        S_RES: begin
          if (resident_done) begin
            st_nxt = S_POLL;
          end
        end
        S_POLL: begin
          if (pif.take && path_ok) begin
            st_nxt = S_SVC;
          end
        end
        S_SVC: begin
          if (xfer_done) begin
            st_nxt = S_POLL;
          end
        end
        default: st_nxt = st_r;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= S_OFF;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Mode indications and start pulses, registered off the next state; host stall is held low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_start_r <= 1'b0;
      resident_load_r <= 1'b0;
      recording_r <= 1'b0;
      halted_r <= 1'b0;
      host_stall_r <= 1'b0;
    end else if (ce) begin
      load_start_r <= st_nxt == S_LOAD && (st_r != S_LOAD || load_req || err_act);
      resident_load_r <= st_nxt == S_RES && st_r == S_LOAD;
      recording_r <= st_nxt == S_POLL || st_nxt == S_SVC;
      halted_r <= st_nxt == S_HALT;
      // The observer only listens to trace lines; it never holds the host.
      host_stall_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Transfer launch.
  // ==========================================================================
  // At most one launch per grant, and no grant exists while a transfer is open.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_go_r <= 1'b0;
      xfer_src_r <= 2'h0;
      xfer_dst_r <= 2'h0;
    end else if (ce) begin
      xfer_go_r <= st_r == S_POLL && st_nxt == S_SVC;
      if (st_r == S_POLL && st_nxt == S_SVC) begin
        xfer_src_r <= pif.gidx;
        xfer_dst_r <= pif.gdst;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xcnt_r <= '0;
    end else if (ce && st_r == S_SVC && st_nxt == S_POLL) begin
      xcnt_r <= xcnt_r + XCNT_W'(1);
    end
  end

  // ==========================================================================
  // Events and interrupt.
  // ==========================================================================
  always_comb begin
    ev = '0;
    ev[EV_LOAD_OK] = st_r == S_RES && st_nxt == S_POLL;
    ev[EV_HALT] = st_r != S_HALT && st_nxt == S_HALT;
    ev[EV_XDONE] = st_r == S_SVC && st_nxt == S_POLL;
    ev[EV_BADPATH] = pif.take && !path_ok;
    ev[EV_INTERR] = err_act;
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else if (ce) begin
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ==========================================================================
  // AXI4-Lite slave.
  // ==========================================================================
  // Address and data are taken together, one write and one read at a time.
  assign wr_fire = ce && s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign wr_ok = s_axi_awaddr == ADDR_CTRL || s_axi_awaddr == ADDR_IRQ_STAT ||
                 s_axi_awaddr == ADDR_IRQ_MASK;
  assign w1c = (wr_fire && s_axi_wstrb[0] && s_axi_awaddr == ADDR_IRQ_STAT) ?
               s_axi_wdata[EV_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awready) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid) begin
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end else if (s_axi_awvalid && s_axi_wvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control and mask writes; the load bit is a one-cycle request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      poll_en_r <= CTRL_POLL_EN_RST;
      sw_load_r <= 1'b0;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (ce) begin
      sw_load_r <= 1'b0;
      if (wr_fire && s_axi_wstrb[0]) begin
        if (s_axi_awaddr == ADDR_CTRL) begin
          poll_en_r <= s_axi_wdata[CTRL_POLL_EN];
          sw_load_r <= s_axi_wdata[CTRL_LOAD];
        end
        if (s_axi_awaddr == ADDR_IRQ_MASK) begin
          irq_mask_r <= s_axi_wdata[EV_W-1:0];
        end
      end
    end
  end

  // Read decode; unmapped addresses read zero with a slave error.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL: rd_val[CTRL_POLL_EN] = poll_en_r;
      ADDR_STAT: begin
        rd_val[ST_POWER] = power_en_r;
        rd_val[ST_REC] = recording_r;
        rd_val[ST_HALT] = halted_r;
        rd_val[ST_BUSY] = st_r == S_SVC;
        rd_val[ST_PEND +: NREQ] = pif.pend;
        rd_val[ST_STATE +: 3] = st_r;
      end
      ADDR_IRQ_STAT: rd_val[EV_W-1:0] = irq_stat_r;
      ADDR_IRQ_MASK: rd_val[EV_W-1:0] = irq_mask_r;
      ADDR_XCNT: rd_val[XCNT_W-1:0] = xcnt_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  AST_REMOTE_FOLLOW: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && pwr_sel_remote |=> power_en_r == $past(host_power_on))
    else $error("Power did not follow the host in remote mode.");

  AST_LOCAL_BTN: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !pwr_sel_remote && !panel_pwr_on_btn && !panel_pwr_off_btn
    |=> power_en_r == $past(power_en_r))
    else $error("Local power changed without a panel button.");

  AST_LOAD_ON_POWER: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st_r == S_OFF && power_nxt |=> load_start_r && st_r == S_LOAD)
    else $error("Power-up did not start the diagnostic load.");

  AST_LOAD_BTN: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && power_nxt && panel_load_btn |=> load_start_r && st_r == S_LOAD)
    else $error("Load button did not start the diagnostic load.");

  AST_RECORD: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st_r == S_RES && resident_done && power_nxt && !load_req && !err_act
    |=> recording_r && st_r == S_POLL)
    else $error("Recording mode not entered after a good load.");

  AST_NO_STEAL: assert property (@(posedge aclk) disable iff (!aresetn)
    recording_r |-> !host_stall_r)
    else $error("Host stalled while recording.");

  AST_ERR_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && err_act && err_stop_sel && power_nxt && !load_req |=> halted_r && !recording_r)
    else $error("Error with stop selected did not halt.");

  AST_ERR_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && err_act && !err_stop_sel && power_nxt |=> load_start_r && st_r == S_LOAD)
    else $error("Error without stop did not restart the load.");

  AST_ONE_XFER: assert property (@(posedge aclk) disable iff (!aresetn)
    xfer_go_r && $past(ce) |-> $past(st_r) == S_POLL && st_r == S_SVC)
    else $error("Transfer launched while another was open.");

  AST_RES_AFTER_DIAG: assert property (@(posedge aclk) disable iff (!aresetn)
    resident_load_r && $past(ce) |-> $past(diag_done) && $past(diag_pass))
    else $error("Resident load without a passed diagnostic load.");

  AST_RESUME: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st_r == S_SVC && xfer_done && power_nxt && !load_req && !err_act
    |=> st_r == S_POLL)
    else $error("Polling did not resume after the transfer.");

  AST_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
    xfer_go_r |-> sps_path_ok(xfer_src_r, xfer_dst_r))
    else $error("Transfer started on an unsupported path.");

endmodule

// ===== test/service_processor_supervisor_tb.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench: AXI master, panel stimulus and result queues.
module service_processor_supervisor_tb;
  import sps_pkg::*;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb, dly;
  logic [1:0] s_axi_bresp, s_axi_rresp, xfer_src_r, xfer_dst_r, s, d;
  logic pwr_sel_remote, host_power_on, panel_pwr_on_btn, panel_pwr_off_btn, panel_load_btn;
  logic err_stop_sel, internal_error, diag_done, diag_pass, resident_done, xfer_done, fail;
  logic power_en_r, load_start_r, resident_load_r, recording_r, halted_r, host_stall_r;
  logic xfer_go_r, irq_r, inflight;
  logic [NREQ-1:0] req;
  logic [2*NREQ-1:0] req_dst;
  logic [33:0] rq[$];
  logic [3:0] xq[$];
  logic [1:0] bq[$];
  int bad_count, n_tests, seed, xi;

  sps_supervisor i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pwr_sel_remote, .host_power_on, .panel_pwr_on_btn,
    .panel_pwr_off_btn, .panel_load_btn, .err_stop_sel, .internal_error, .diag_done,
    .diag_pass, .resident_done, .req, .req_dst, .xfer_done, .power_en_r, .load_start_r,
    .resident_load_r, .recording_r, .halted_r, .host_stall_r, .xfer_go_r, .xfer_src_r,
    .xfer_dst_r, .irq_r);
  sps_far_model i_far (.aclk, .aresetn, .load_start_r, .resident_load_r, .xfer_go_r, .fail,
    .dly, .diag_done, .diag_pass, .resident_done, .xfer_done);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Each channel drops its valid at the edge at which its own ready is seen.
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Bounded wait on recording (0), halted (1), power (2) or transfer done (3).
  task automatic wait_on(input int k, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (n < 200 && v !== (k == 0 ? recording_r : k == 1 ? halted_r :
      k == 2 ? power_en_r : xfer_done));
    chk(34'(n < 200), 34'h1);
  endtask

  // Destinations are only valid during the pulse, so they toggle afterwards.
  task automatic send(input logic [2:0] r, input logic [5:0] dd);
    req <= r;
    req_dst <= dd;
    @(posedge aclk);
    req <= 3'h0;
    req_dst <= ~dd;
  endtask

  task automatic press(input int k);
    case (k)
      0: panel_pwr_on_btn <= 1'b1;
      1: panel_pwr_off_btn <= 1'b1;
      2: panel_load_btn <= 1'b1;
      default: internal_error <= 1'b1;
    endcase
    @(posedge aclk);
    {panel_pwr_on_btn, panel_pwr_off_btn, panel_load_btn, internal_error} <= 4'h0;
  endtask

  // Results are compared against the oldest note; simultaneous requests may swap order.
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(bq.pop_front()));
    if (recording_r) chk(34'(host_stall_r), 34'h0);
    if (xfer_go_r) begin
      chk(34'(inflight), 34'h0);
      xi = (xq.size() > 1 && xq[0] !== {xfer_src_r, xfer_dst_r}) ? 1 : 0;
      chk(34'({xfer_src_r, xfer_dst_r}), 34'(xq[xi]));
      xq.delete(xi);
    end
    inflight = xfer_go_r | (inflight & !xfer_done);
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    wrap_up();
  end

  initial begin
    seed = 32'hB0D64BC8;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {pwr_sel_remote, host_power_on, panel_pwr_on_btn, panel_pwr_off_btn} = 4'h0;
    {panel_load_btn, err_stop_sel, internal_error, fail, inflight} = 5'h00;
    {ce, s_axi_wstrb, dly, req, req_dst} = {1'b1, 4'hF, 4'h2, 3'h0, 6'h00};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL, {RESP_OKAY, 32'h1});
    rd(ADDR_IRQ_MASK, {RESP_OKAY, 32'h0});
    rd(ADDR_STAT, {RESP_OKAY, 32'h0});
    rd(8'h14, {RESP_SLVERR, 32'h0});
    wr(ADDR_STAT, 32'h1, RESP_SLVERR);
    // Local power-up through the panel, then the interrupt path.
    press(0);
    wait_on(0, 1'b1);
    rd(ADDR_STAT, {RESP_OKAY, 32'h303});
    rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h1});
    chk(34'(irq_r), 34'h0);
    wr(ADDR_IRQ_MASK, 32'h1F, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(34'(irq_r), 34'h1);
    wr(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(34'(irq_r), 34'h0);
    // A low clock enable freezes the unit, so this off press is never seen.
    ce <= 1'b0;
    press(1);
    @(posedge aclk);
    chk(34'({power_en_r, recording_r}), 34'h3);
    ce <= 1'b1;
    // Random legal transfers with random far-side speed.
    for (int i = 0; i < 12; i++) begin
      rv = $random(seed);
      s = 2'(rv[15:8] % 3);
      d = s == 2'd0 ? 2'd0 : s == 2'd1 ? 2'(rv[3:2] % 3 + 1) : (rv[0] ? 2'd3 : 2'd0);
      dly <= rv[7:4];
      xq.push_back({s, d});
      send(3'(1 << s), 6'(d) << (2 * s));
      wait_on(3, 1'b1);
    end
    send(3'h1, 6'h01);
    // Let the refused request be scanned before the same requester asks again.
    repeat (4) @(posedge aclk);
    xq.push_back(4'h0);
    xq.push_back(4'hB);
    send(3'h5, 6'h30);
    wait_on(3, 1'b1);
    wait_on(3, 1'b1);
    rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'hC});
    rd(ADDR_XCNT, {RESP_OKAY, 32'd14});
    // A request stays pending while polling is suspended.
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    send(3'h2, 6'h0C);
    repeat (20) @(posedge aclk);
    rd(ADDR_STAT, {RESP_OKAY, 32'h323});
    xq.push_back(4'h7);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    wait_on(3, 1'b1);
    // Internal errors with the switch at stop and not at stop, then a failing load.
    err_stop_sel <= 1'b1;
    press(3);
    wait_on(1, 1'b1);
    rd(ADDR_STAT, {RESP_OKAY, 32'h505});
    wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    wait_on(0, 1'b1);
    err_stop_sel <= 1'b0;
    press(3);
    wait_on(0, 1'b0);
    wait_on(0, 1'b1);
    fail <= 1'b1;
    press(2);
    wait_on(1, 1'b1);
    fail <= 1'b0;
    press(2);
    wait_on(0, 1'b1);
    // Local off button, host ignored in local, then remote follows the host.
    press(1);
    wait_on(2, 1'b0);
    host_power_on <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(34'(power_en_r), 34'h0);
    pwr_sel_remote <= 1'b1;
    wait_on(0, 1'b1);
    host_power_on <= 1'b0;
    wait_on(2, 1'b0);
    rd(ADDR_STAT, {RESP_OKAY, 32'h0});
    wrap_up();
  end
endmodule

// ===== test/sps_far_model.sv
`timescale 1ns/1ps
// ============================================================
// Far side: diagnostics, resident loader and transfer engine.
module sps_far_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load_start_r,
  input wire logic resident_load_r,
  input wire logic xfer_go_r,
  input wire logic fail,
  input wire logic [3:0] dly,
  output logic diag_done,
  output logic diag_pass,
  output logic resident_done,
  output logic xfer_done
);
  logic [4:0] dcnt_r;
  logic [4:0] rcnt_r;
  logic [4:0] xcnt_r;
  // A fresh load start restarts the run; the verdict line toggles when not valid.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dcnt_r <= 5'h00;
      diag_done <= 1'b0;
      diag_pass <= 1'b0;
    end else begin
      dcnt_r <= load_start_r ? {1'b0, dly} + 5'h01 : dcnt_r - 5'(dcnt_r != 5'h00);
      diag_done <= (dcnt_r == 5'h01) && !load_start_r;
      diag_pass <= (dcnt_r == 5'h01) ? !fail : ~diag_pass;
    end
  end
  // Resident load takes a fixed short time, a transfer a variable one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcnt_r <= 5'h00;
      xcnt_r <= 5'h00;
      resident_done <= 1'b0;
      xfer_done <= 1'b0;
    end else begin
      rcnt_r <= resident_load_r ? 5'h03 : rcnt_r - 5'(rcnt_r != 5'h00);
      resident_done <= rcnt_r == 5'h01;
      xcnt_r <= xfer_go_r ? {1'b0, dly} + 5'h01 : xcnt_r - 5'(xcnt_r != 5'h00);
      xfer_done <= xcnt_r == 5'h01;
    end
  end
endmodule
